//--- src/acr_pkg.sv
package acr_pkg;

  // ---------------------------------------------------------------
  // frame layout of the serial control port
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 7;
  localparam int CNT_BITS = 5;
  localparam int RW_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h08;
  localparam logic [4:0] CNT_FRAME_DONE = 5'h10;
  localparam int SYNC_LAG = 3;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] A_SLEEP = 7'h00;
  localparam logic [6:0] A_RATE_A = 7'h01;
  localparam logic [6:0] A_RATE_B = 7'h02;
  localparam logic [6:0] A_GROUP = 7'h03;
  localparam logic [6:0] A_POWER = 7'h04;
  localparam logic [6:0] A_SETUP = 7'h05;
  localparam logic [6:0] A_CONV = 7'h06;
  localparam logic [6:0] A_PORT = 7'h07;
  localparam logic [6:0] A_BIST = 7'h08;
  localparam logic [6:0] A_HEALTH = 7'h09;
  localparam logic [6:0] A_VERSION = 7'h0A;
  localparam logic [6:0] A_SPARE_B = 7'h0B;
  localparam logic [6:0] A_SPARE_C = 7'h0C;
  localparam logic [6:0] A_SPARE_D = 7'h0D;
  localparam logic [6:0] A_DIR = 7'h0E;
  localparam logic [6:0] A_OUT = 7'h0F;
  localparam logic [6:0] A_IN = 7'h10;
  localparam logic [6:0] A_PRE_LO = 7'h11;
  localparam logic [6:0] A_PRE_HI = 7'h12;
  localparam logic [6:0] A_REFP = 7'h13;
  localparam logic [6:0] A_REFN = 7'h14;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] R_SLEEP = 8'h00;
  localparam logic [7:0] R_RATE_A = 8'h0D;
  localparam logic [7:0] R_RATE_B = 8'h0D;
  localparam logic [7:0] R_GROUP = 8'h00;
  localparam logic [7:0] R_POWER = 8'h00;
  localparam logic [7:0] R_SETUP = 8'h08;
  localparam logic [7:0] R_CONV = 8'h80;
  localparam logic [7:0] R_ZERO = 8'h00;
  localparam logic [7:0] R_PRE = 8'hFF;
  localparam logic [7:0] R_REF = 8'h00;

  // ---------------------------------------------------------------
  // aux pin fields
  // ---------------------------------------------------------------
  localparam int AUX_PINS = 5;
  localparam int AUX_ON_POS = 7;
  localparam logic [2:0] AUX_PAD = 3'h0;

endpackage

//--- src/acr_pin_sync.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ---------------------------------------------------------------
module acr_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // three flops; first only feeds second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit changes once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          level[i] <= INIT[i];
        end else if (s2_r[i] == s3_r[i]) begin
          level[i] <= s3_r[i];
        end
      end
    end
  endgenerate

endmodule

//--- src/acr_regs.sv
`timescale 1ns/100ps
// Operation
// - five aux pins operable over serial port
// - each pin direction chosen independently
// - direction register holds enable and directions
// - output pins drive write-data register bits
// - input pin levels read from read-data register
// - positive reference enables, one per channel, zero
// - negative reference enables, one per channel, zero
module acr_regs #(
  parameter logic [7:0] VERSION_CODE = 8'h5A // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo_o,
  output logic spi_sdo_oe,
  input wire logic [4:0] aux_pin_i,
  output logic [4:0] aux_pin_o,
  output logic [4:0] aux_pin_oe,
  input wire logic [7:0] health_in,
  output logic [7:0] channel_sleep_mask,
  output logic [7:0] group_a_filter_rate,
  output logic [7:0] group_b_filter_rate,
  output logic [7:0] channel_group_assign,
  output logic [7:0] power_setting,
  output logic [7:0] general_setup,
  output logic [7:0] conversion_control,
  output logic [7:0] port_setup,
  output logic [7:0] memory_selftest_ctrl,
  output logic [7:0] input_precharge_lo,
  output logic [7:0] input_precharge_hi,
  output logic [7:0] refp_precharge_enables,
  output logic [7:0] refn_precharge_enables
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] spi_lvl;
  logic [4:0] aux_in_lvl;
  logic sclk_f;
  logic cs_n_f;
  logic sdi_f;

  // serial pins: sclk, chip select (idle high), data in
  acr_pin_sync #(.W(3), .INIT(3'h2)) u_spi_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({spi_sclk, spi_cs_n, spi_sdi}),
    .level(spi_lvl)
  );

  // aux pin input levels
  acr_pin_sync #(.W(acr_pkg::AUX_PINS), .INIT(5'h00)) u_aux_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(aux_pin_i),
    .level(aux_in_lvl)
  );

  assign sclk_f = spi_lvl[2];
  assign cs_n_f = spi_lvl[1];
  assign sdi_f = spi_lvl[0];

  // ---------------------------------------------------------------
  // serial frame engine
  // ---------------------------------------------------------------
  logic sclk_q_r;
  logic [4:0] bit_cnt_r;
  logic [14:0] shin_r;
  logic [7:0] shout_r;
  logic sdo_r;
  logic sclk_rise;
  logic sclk_fall;
  logic [15:0] frame_word;
  logic wr_stb;
  logic rd_load;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;

  assign sclk_rise = sclk_f & ~sclk_q_r & ~cs_n_f;
  assign sclk_fall = ~sclk_f & sclk_q_r & ~cs_n_f;
  assign frame_word = {shin_r, sdi_f};

  // edge history of filtered clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= sclk_f;
    end
  end

  // bit counter, saturates at frame end until deselect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 5'h00;
    end else if (cs_n_f) begin
      bit_cnt_r <= 5'h00;
    end else if (sclk_rise && bit_cnt_r != acr_pkg::CNT_FRAME_DONE) begin
      bit_cnt_r <= 5'(bit_cnt_r + 5'h01);
    end
  end

  // input shifter, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shin_r <= 15'h0000;
    end else if (sclk_rise && bit_cnt_r != acr_pkg::CNT_FRAME_DONE) begin
      shin_r <= frame_word[14:0];
    end
  end

  assign wr_stb = sclk_rise && (bit_cnt_r == 5'(acr_pkg::CNT_FRAME_DONE - 5'h01))
                  && !shin_r[acr_pkg::RW_POS-1];
  assign wr_addr = frame_word[acr_pkg::ADDR_MSB:acr_pkg::ADDR_LSB];
  assign wr_data = frame_word[7:0];
  assign rd_load = sclk_rise && (bit_cnt_r == 5'(acr_pkg::CNT_ADDR_DONE - 5'h01))
                   && shin_r[6];
  assign rd_addr = frame_word[6:0];

  // read shifter: load after address, shift on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shout_r <= 8'h00;
      sdo_r <= 1'b0;
    end else if (rd_load) begin
      shout_r <= rd_data;
    end else if (sclk_fall && bit_cnt_r >= acr_pkg::CNT_ADDR_DONE) begin
      sdo_r <= shout_r[7];
      shout_r <= {shout_r[6:0], 1'b0};
    end
  end

  assign spi_sdo_o = sdo_r;
  assign spi_sdo_oe = ~cs_n_f;

  // ---------------------------------------------------------------
  // converter configuration registers
  // ---------------------------------------------------------------
  logic [7:0] sleep_r;
  logic [7:0] rate_a_r;
  logic [7:0] rate_b_r;
  logic [7:0] group_r;
  logic [7:0] power_r;
  logic [7:0] setup_r;
  logic [7:0] conv_r;
  logic [7:0] port_r;
  logic [7:0] bist_r;
  logic [7:0] pre_lo_r;
  logic [7:0] pre_hi_r;

  // writable configuration bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_r <= acr_pkg::R_SLEEP;
      rate_a_r <= acr_pkg::R_RATE_A;
      rate_b_r <= acr_pkg::R_RATE_B;
      group_r <= acr_pkg::R_GROUP;
      power_r <= acr_pkg::R_POWER;
      setup_r <= acr_pkg::R_SETUP;
      conv_r <= acr_pkg::R_CONV;
      port_r <= acr_pkg::R_ZERO;
      bist_r <= acr_pkg::R_ZERO;
      pre_lo_r <= acr_pkg::R_PRE;
      pre_hi_r <= acr_pkg::R_PRE;
    end else if (wr_stb) begin
      // unmapped and read-only offsets fall through
      case (wr_addr)
        acr_pkg::A_SLEEP: sleep_r <= wr_data;
        acr_pkg::A_RATE_A: rate_a_r <= wr_data;
        acr_pkg::A_RATE_B: rate_b_r <= wr_data;
        acr_pkg::A_GROUP: group_r <= wr_data;
        acr_pkg::A_POWER: power_r <= wr_data;
        acr_pkg::A_SETUP: setup_r <= wr_data;
        acr_pkg::A_CONV: conv_r <= wr_data;
        acr_pkg::A_PORT: port_r <= wr_data;
        acr_pkg::A_BIST: bist_r <= wr_data;
        acr_pkg::A_PRE_LO: pre_lo_r <= wr_data;
        acr_pkg::A_PRE_HI: pre_hi_r <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // reference precharge enables
  // ---------------------------------------------------------------
  logic [7:0] refp_r;
  logic [7:0] refn_r;

  // positive enables, bit n is channel n
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refp_r <= acr_pkg::R_REF;
    end else if (wr_stb && wr_addr == acr_pkg::A_REFP) begin
      refp_r <= wr_data;
    end
  end

  // negative enables, bit n is channel n
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refn_r <= acr_pkg::R_REF;
    end else if (wr_stb && wr_addr == acr_pkg::A_REFN) begin
      refn_r <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // aux pin expander
  // ---------------------------------------------------------------
  logic [7:0] dir_r;
  logic [7:0] out_r;
  logic aux_on;
  logic [4:0] in_levels;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= acr_pkg::R_ZERO;
    end else if (wr_stb && wr_addr == acr_pkg::A_DIR) begin
      dir_r <= wr_data;
    end
  end

  // output levels held for driven pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= acr_pkg::R_ZERO;
    end else if (wr_stb && wr_addr == acr_pkg::A_OUT) begin
      out_r <= wr_data;
    end
  end

  assign aux_on = dir_r[acr_pkg::AUX_ON_POS];

  // each pin driven only when enabled and set as output
  assign aux_pin_oe = {acr_pkg::AUX_PINS{aux_on}} & dir_r[4:0];
  assign aux_pin_o = out_r[4:0];

  // input pins report their level, outputs read zero
  assign in_levels = aux_in_lvl & ~dir_r[4:0];

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  always_comb begin
    case (rd_addr)
      acr_pkg::A_SLEEP: rd_data = sleep_r;
      acr_pkg::A_RATE_A: rd_data = rate_a_r;
      acr_pkg::A_RATE_B: rd_data = rate_b_r;
      acr_pkg::A_GROUP: rd_data = group_r;
      acr_pkg::A_POWER: rd_data = power_r;
      acr_pkg::A_SETUP: rd_data = setup_r;
      acr_pkg::A_CONV: rd_data = conv_r;
      acr_pkg::A_PORT: rd_data = port_r;
      acr_pkg::A_BIST: rd_data = bist_r;
      acr_pkg::A_HEALTH: rd_data = health_in;
      acr_pkg::A_VERSION: rd_data = VERSION_CODE;
      acr_pkg::A_DIR: rd_data = dir_r;
      acr_pkg::A_OUT: rd_data = out_r;
      acr_pkg::A_IN: rd_data = {acr_pkg::AUX_PAD, in_levels};
      acr_pkg::A_PRE_LO: rd_data = pre_lo_r;
      acr_pkg::A_PRE_HI: rd_data = pre_hi_r;
      acr_pkg::A_REFP: rd_data = refp_r;
      acr_pkg::A_REFN: rd_data = refn_r;
      default: rd_data = 8'h00;
    endcase
  end

  // configuration outputs straight from flops
  assign channel_sleep_mask = sleep_r;
  assign group_a_filter_rate = rate_a_r;
  assign group_b_filter_rate = rate_b_r;
  assign channel_group_assign = group_r;
  assign power_setting = power_r;
  assign general_setup = setup_r;
  assign conversion_control = conv_r;
  assign port_setup = port_r;
  assign memory_selftest_ctrl = bist_r;
  assign input_precharge_lo = pre_lo_r;
  assign input_precharge_hi = pre_hi_r;
  assign refp_precharge_enables = refp_r;
  assign refn_precharge_enables = refn_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_wr_dir;
    wr_stb && wr_addr == acr_pkg::A_DIR;
  endsequence

  sequence s_wr_out;
    wr_stb && wr_addr == acr_pkg::A_OUT;
  endsequence

  sequence s_rd_in;
    rd_load && rd_addr == acr_pkg::A_IN;
  endsequence

  property p_aux_off;
    @(posedge clk) disable iff (!rst_n)
      !dir_r[acr_pkg::AUX_ON_POS] |-> aux_pin_oe == 5'h00;
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux pin driven while disabled");

  property p_dir_each;
    logic [7:0] v;
    @(posedge clk) disable iff (!rst_n)
      (s_wr_dir, v = wr_data) |=> aux_pin_oe == ({5{v[7]}} & v[4:0]);
  endproperty
  a_dir_each: assert property (p_dir_each) else $error("pin enables do not follow direction write");

  property p_dir_store;
    @(posedge clk) disable iff (!rst_n)
      s_wr_dir |=> dir_r == $past(wr_data) ##1 ($stable(dir_r) || $past(wr_stb));
  endproperty
  a_dir_store: assert property (p_dir_store) else $error("direction register not stored");

  property p_out_level;
    @(posedge clk) disable iff (!rst_n)
      s_wr_out |=> aux_pin_o == $past(wr_data[4:0]);
  endproperty
  a_out_level: assert property (p_out_level) else $error("output level not driven");

  property p_in_read;
    @(posedge clk) disable iff (!rst_n)
      s_rd_in |=> shout_r == {3'h0, $past(aux_in_lvl) & ~$past(dir_r[4:0])};
  endproperty
  a_in_read: assert property (p_in_read) else $error("input levels not loaded for read");

  property p_refp;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && wr_addr == acr_pkg::A_REFP |=> refp_precharge_enables == $past(wr_data);
  endproperty
  a_refp: assert property (p_refp) else $error("positive enables not written");

  property p_refn;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && wr_addr == acr_pkg::A_REFN |=> refn_precharge_enables == $past(wr_data);
  endproperty
  a_refn: assert property (p_refn) else $error("negative enables not written");

  property p_ro_write;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_addr == acr_pkg::A_IN || wr_addr == acr_pkg::A_HEALTH || wr_addr > acr_pkg::A_REFN)
      |=> $stable(dir_r) && $stable(out_r) && $stable(refp_r) && $stable(refn_r) && $stable(conv_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

endmodule

//--- verif/acr_host.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host controller model: serial master, mode 0
// ---------------------------------------------------------------
module acr_host #(
  parameter int HALF = 10
) (
  input wire logic clk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  // idle: deselected, clock parked low
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end

  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] word;
    word = {rd, addr, wdata};
    rdata = 8'h00;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi <= word[i];
      repeat (HALF) @(posedge clk);
      if (i < 8) begin
        rdata[i] = spi_sdo; // sampled just before the rise
      end
      spi_sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      spi_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    spi_cs_n <= 1'b1;
    spi_sdi <= ~word[0]; // released line must not look held
    repeat (HALF + 2) @(posedge clk);
  endtask
endmodule

//--- verif/test_adc_control_regs_gpio.sv
`timescale 1ns/100ps
module test_adc_control_regs_gpio;
  localparam logic [7:0] VER = 8'h3C; // arbitrary value
  localparam logic [7:0] HEALTH = 8'hA5;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic rst_n;
  logic sclk, cs_n, sdi, sdo_o, sdo_oe;
  wire logic sdo;
  logic [4:0] aux_i, aux_o, aux_oe;
  logic [7:0] health;
  wire logic [7:0] cfg [13];
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  // ---------------------------------------------------------------
  // clock, wiring and instances
  // ---------------------------------------------------------------
  always #4 clk = ~clk;
  assign sdo = sdo_oe ? sdo_o : 1'bz;

  acr_host host (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo));

  acr_regs #(.VERSION_CODE(VER)) dut (
    .clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .spi_sdo_o(sdo_o), .spi_sdo_oe(sdo_oe), .aux_pin_i(aux_i), .aux_pin_o(aux_o),
    .aux_pin_oe(aux_oe), .health_in(health), .channel_sleep_mask(cfg[0]),
    .group_a_filter_rate(cfg[1]), .group_b_filter_rate(cfg[2]), .channel_group_assign(cfg[3]),
    .power_setting(cfg[4]), .general_setup(cfg[5]), .conversion_control(cfg[6]),
    .port_setup(cfg[7]), .memory_selftest_ctrl(cfg[8]), .input_precharge_lo(cfg[9]),
    .input_precharge_hi(cfg[10]), .refp_precharge_enables(cfg[11]), .refn_precharge_enables(cfg[12])
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer(1'b0, a, d, unused);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host.xfer(1'b1, a, 8'h00, d);
  endtask

  function automatic logic [6:0] addr_of(input int i);
    return (i == 21) ? 7'h7F : 7'(i);
  endfunction

  function automatic int cfg_idx(input logic [6:0] a);
    if (a <= 7'h08) return int'(a);
    if (a >= 7'h11 && a <= 7'h14) return int'(a) - 8;
    return -1;
  endfunction

  function automatic bit is_rw(input logic [6:0] a);
    return cfg_idx(a) >= 0 || a == acr_pkg::A_DIR || a == acr_pkg::A_OUT;
  endfunction

  function automatic logic [7:0] pat(input logic [6:0] a);
    return 8'hC3 ^ {1'h0, a};
  endfunction

  // value a location holds when never written
  function automatic logic [7:0] fixed(input logic [6:0] a);
    case (a)
      acr_pkg::A_RATE_A, acr_pkg::A_RATE_B: return acr_pkg::R_RATE_A;
      acr_pkg::A_SETUP: return acr_pkg::R_SETUP;
      acr_pkg::A_CONV: return acr_pkg::R_CONV;
      acr_pkg::A_PRE_LO, acr_pkg::A_PRE_HI: return acr_pkg::R_PRE;
      acr_pkg::A_HEALTH: return HEALTH;
      acr_pkg::A_VERSION: return VER;
      default: return 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // read every location except A_IN, compare bus answer and register port
  task automatic scan(input bit written);
    logic [7:0] d, e;
    logic [6:0] a;
    for (int i = 0; i < 22; i++) begin
      a = addr_of(i);
      if (a != acr_pkg::A_IN) begin
        e = (written && is_rw(a)) ? pat(a) : fixed(a);
        rd(a, d);
        check(d, e);
        if (cfg_idx(a) >= 0) begin
          check(cfg[cfg_idx(a)], e);
        end
      end
    end
  endtask

  // write every location, read-only and unmapped ones too
  task automatic write_all();
    for (int i = 0; i < 22; i++) begin
      wr(addr_of(i), pat(addr_of(i)));
    end
  endtask

  // mixed directions, master enable, input readback
  task automatic aux_test();
    logic [7:0] d;
    aux_i <= 5'h1F;
    wr(acr_pkg::A_OUT, 8'h1F);
    wr(acr_pkg::A_DIR, 8'h95);
    check({3'h0, aux_oe}, 8'h15);
    check({3'h0, aux_o}, 8'h1F);
    rd(acr_pkg::A_IN, d);
    check(d, 8'h0A);
    wr(acr_pkg::A_OUT, 8'h0A);
    check({3'h0, aux_o & aux_oe}, 8'h00);
    wr(acr_pkg::A_DIR, 8'h8A);
    check({3'h0, aux_oe}, 8'h0A);
    check({3'h0, aux_o & aux_oe}, 8'h0A);
    aux_i <= 5'h15;
    rd(acr_pkg::A_IN, d);
    check(d, 8'h15);
    wr(acr_pkg::A_DIR, 8'h1F);
    check({3'h0, aux_oe}, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    rst_n = 1'b0;
    aux_i = 5'h00;
    health = HEALTH;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({3'h0, aux_oe}, 8'h00);
    check({6'h00, sdo_oe, sdo_o}, 8'h00);
    scan(1'b0);
    write_all();
    scan(1'b1);
    aux_test();
    report_and_stop();
  end
endmodule
